// ==== common/rcf_pkg.sv ====
/*
  Package of the reset and clock fail-safe controller: APB carriers, register offsets,
  field positions, reset values and cycle counts.
  Assumes a 20 MHz mclk and a zero-wait APB master with 8-bit byte addresses.
*/
package rcf_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rcf_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rcf_apb_rsp_s;

  typedef enum logic {SW_IDLE, SW_BUSY} rcf_switch_e;

  localparam logic [7:0] OFF_OSC = 8'h00;
  localparam logic [7:0] OFF_CAUSE = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h10;
  localparam logic [7:0] OFF_IRQ_EN = 8'h14;

  localparam int OSC_NXT_LSB = 0;
  localparam int OSC_CUR_LSB = 4;
  localparam int OSC_FAIL_BIT = 8;
  localparam int OSC_STUCK_BIT = 9;
  localparam int OSC_FAILSAFE_CLOCK_MONITOR_EN_BIT = 12;
  localparam int OSC_REQ_BIT = 16;
  localparam int CAUSE_WDT_BIT = 0;
  localparam int CAUSE_EXT_BIT = 1;
  localparam int CAUSE_SOFT_BIT = 2;
  localparam int CTRL_SWRST_BIT = 0;
  localparam int CTRL_DIV_LSB = 1;
  localparam int CTRL_WDT_EN_BIT = 3;
  localparam int CTRL_WDT_KICK_BIT = 4;
  localparam int IRQ_EXT_BIT = 0;
  localparam int IRQ_SOFT_BIT = 1;
  localparam int IRQ_WDT_BIT = 2;
  localparam int IRQ_FAILSAFE_CLOCK_MONITOR_BIT = 3;
  localparam int IRQ_SWFAIL_BIT = 4;
  localparam int IRQ_W = 5;

  localparam logic [2:0] SRC_FAST_RC = 3'h0;
  localparam logic [2:0] SRC_RST = 3'h0;
  localparam logic [1:0] DIV_ONE_TO_ONE = 2'h0;
  localparam logic [2:0] PIN_IDLE = 3'h1;

  localparam int unsigned MCLK_HZ = 20_000_000;
  localparam int unsigned EXT_MIN_CORE_SYSTEM_CLOCK = 2;
  localparam logic [3:0] EXT_VALID_CNT = 4'(EXT_MIN_CORE_SYSTEM_CLOCK + 1);
  localparam logic [3:0] RST_HOLD_CYC = 4'h4;
  localparam logic [3:0] SWITCH_CYC = 4'h8;
  localparam int unsigned WDT_NEAR_CYC = 16;
endpackage : rcf_pkg

// ==== hdl/rcf_reset_clock_failsafe.sv ====
/*
  Reset generation, reset-cause flags, watchdog, fail-safe clock monitor and oscillator
  switch control, with an APB register slave and one level interrupt.
  Assumes external_reset_pin_n, ref_clk_31k and clk_fail_pin are asynchronous pins;
  osc_ready and core_clk_below_1mhz come from clock logic on mclk.
*/
// Implementation choices: the APB register port and the placing of the registers.
// Contract
// - External reset pulses of two cycles or fewer do not reset the device.
// - A reset longer than one 31 kHz period raises a monitor event when enabled.
// - Software reset is dropped when bus divider is 1:1 and clock below 1 MHz.
// - After clock failure any oscillator control write clears failsafe and starts a switch.
// - Pin or software reset near watchdog expiry also flags a watchdog timeout.
// - Watchdog, pin and software causes are separate flags; firmware checks watchdog alone.
// - After a monitor event one failed switch away from fast RC makes all retries fail.
`timescale 1ns/10ps
module rcf_reset_clock_failsafe #(
  parameter int unsigned WDT_TIMEOUT_CYC = 20000,
  parameter int unsigned WDT_W = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire rcf_pkg::rcf_apb_req_s apb_req,
  output rcf_pkg::rcf_apb_rsp_s apb_rsp,
  input wire logic external_reset_pin_n,
  input wire logic ref_clk_31k,
  input wire logic clk_fail_pin,
  input wire logic osc_ready,
  input wire logic core_clk_below_1mhz,
  output logic core_reset_out,
  output logic [2:0] clock_source_out,
  output logic irq
);
  logic [2:0] s1_ff, s2_ff, s3_ff, filt_ff, filt_d_ff;
  logic ext_asserted, ref_edge, fail_rise;
  logic [3:0] ext_cnt_ff, hold_cnt_ff, sw_cnt_ff;
  logic ext_valid_ff, core_rst_ff;
  logic [1:0] ref_edges_ff;
  logic [WDT_W-1:0] wdt_cnt_ff;
  logic [2:0] nxt_sel_ff, cur_src_ff, target_ff;
  logic failsafe_ff, failsafe_clock_monitor_en_ff, failsafe_clock_monitor_seen_ff, stuck_ff;
  logic [1:0] div_ff;
  logic wdt_en_ff;
  logic [2:0] cause_ff;
  localparam int IRQ_W_L = rcf_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] irq_stat_ff, irq_en_ff;
  logic irq_ff;
  rcf_pkg::rcf_switch_e sw_state_ff;
  rcf_pkg::rcf_apb_rsp_s rsp_ff;
  localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WDT_TIMEOUT_CYC - 1);
  localparam logic [WDT_W-1:0] WDT_NEAR = WDT_W'(WDT_TIMEOUT_CYC - rcf_pkg::WDT_NEAR_CYC);

  logic wr, setup, wr_osc, wr_cause, wr_ctrl, wr_iclr, wr_ien;
  logic ev_ext, ev_soft, ev_wdt, ev_long, ev_failsafe_clock_monitor, ev_swfail, sw_done, sw_ok, wdt_near, soft_req;
  logic [2:0] cause_keep;
  logic [IRQ_W_L-1:0] irq_ev;

  assign setup = apb_req.psel && !apb_req.penable;
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign wr_osc = wr && apb_req.paddr == rcf_pkg::OFF_OSC;
  assign wr_cause = wr && apb_req.paddr == rcf_pkg::OFF_CAUSE;
  assign wr_ctrl = wr && apb_req.paddr == rcf_pkg::OFF_CTRL;
  assign wr_iclr = wr && apb_req.paddr == rcf_pkg::OFF_IRQ_CLR;
  assign wr_ien = wr && apb_req.paddr == rcf_pkg::OFF_IRQ_EN;

  // Three-stage pin synchronisers; a level is taken only once stages two and three agree
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_ff <= rcf_pkg::PIN_IDLE;
      s2_ff <= rcf_pkg::PIN_IDLE;
      s3_ff <= rcf_pkg::PIN_IDLE;
      filt_ff <= rcf_pkg::PIN_IDLE;
      filt_d_ff <= rcf_pkg::PIN_IDLE;
    end else begin
      s1_ff <= {clk_fail_pin, ref_clk_31k, external_reset_pin_n};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      filt_ff <= (s2_ff & s3_ff) | (filt_ff & (s2_ff ^ s3_ff));
      filt_d_ff <= filt_ff;
    end
  end
  assign ext_asserted = !filt_ff[0];
  assign ref_edge = filt_ff[1] && !filt_d_ff[1];
  assign fail_rise = filt_ff[2] && !filt_d_ff[2];

  // Pin reset counts as valid only after more than two clocks asserted
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ext_cnt_ff <= 4'h0;
      ext_valid_ff <= 1'b0;
    end else if (!ext_asserted) begin
      ext_cnt_ff <= 4'h0;
      ext_valid_ff <= 1'b0;
    end else begin
      if (ext_cnt_ff != rcf_pkg::EXT_VALID_CNT) ext_cnt_ff <= ext_cnt_ff + 4'h1;
      if (ev_ext) ext_valid_ff <= 1'b1;
    end
  end
  assign ev_ext = ext_asserted && ext_cnt_ff == rcf_pkg::EXT_VALID_CNT - 4'h1;

  // A slow core clock with an undivided bus loses the software reset
  assign soft_req = wr_ctrl && apb_req.pwdata[rcf_pkg::CTRL_SWRST_BIT];
  assign ev_soft = soft_req &&
    !(div_ff == rcf_pkg::DIV_ONE_TO_ONE && core_clk_below_1mhz);

  assign wdt_near = wdt_en_ff && wdt_cnt_ff >= WDT_NEAR;
  assign ev_wdt = (wdt_en_ff && !core_rst_ff && wdt_cnt_ff == WDT_LAST) ||
    ((ev_ext || ev_soft) && wdt_near);

  // Internal resets are stretched; registers here survive them except the watchdog counter, which core reset zeroes; only sys_rst clears the rest
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hold_cnt_ff <= 4'h0;
      core_rst_ff <= 1'b0;
    end else begin
      if (ev_soft || ev_wdt) hold_cnt_ff <= rcf_pkg::RST_HOLD_CYC;
      else if (hold_cnt_ff != 4'h0) hold_cnt_ff <= hold_cnt_ff - 4'h1;
      core_rst_ff <= ext_valid_ff || ev_ext || ev_soft || ev_wdt || hold_cnt_ff > 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) wdt_cnt_ff <= '0;
    else if (!wdt_en_ff || core_rst_ff || ev_wdt) wdt_cnt_ff <= '0;
    else if (wr_ctrl && apb_req.pwdata[rcf_pkg::CTRL_WDT_KICK_BIT]) wdt_cnt_ff <= '0;
    else wdt_cnt_ff <= wdt_cnt_ff + WDT_W'(1);
  end

  // Two reference edges inside one reset prove it outlasted a reference period
  always_ff @(posedge mclk) begin
    if (sys_rst || !core_rst_ff) ref_edges_ff <= 2'h0;
    else if (ref_edge && ref_edges_ff != 2'h2) ref_edges_ff <= ref_edges_ff + 2'h1;
  end
  assign ev_long = core_rst_ff && ref_edge && ref_edges_ff == 2'h1;
  assign ev_failsafe_clock_monitor = failsafe_clock_monitor_en_ff && (ev_long || fail_rise);

  // Oscillator control and switch sequencer
  assign sw_done = sw_state_ff == rcf_pkg::SW_BUSY && sw_cnt_ff == 4'h0;
  assign sw_ok = target_ff == rcf_pkg::SRC_FAST_RC || (osc_ready && !stuck_ff);
  assign ev_swfail = sw_done && !sw_ok && !ev_failsafe_clock_monitor;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sw_state_ff <= rcf_pkg::SW_IDLE;
      sw_cnt_ff <= 4'h0;
      target_ff <= rcf_pkg::SRC_RST;
      cur_src_ff <= rcf_pkg::SRC_RST;
      failsafe_ff <= 1'b0;
      failsafe_clock_monitor_seen_ff <= 1'b0;
      stuck_ff <= 1'b0;
    end else if (ev_failsafe_clock_monitor) begin
      sw_state_ff <= rcf_pkg::SW_IDLE;
      cur_src_ff <= rcf_pkg::SRC_FAST_RC;
      failsafe_ff <= 1'b1;
      failsafe_clock_monitor_seen_ff <= 1'b1;
    end else begin
      if (wr_osc && (failsafe_ff || apb_req.pwdata[rcf_pkg::OSC_REQ_BIT])) begin
        failsafe_ff <= 1'b0;
        sw_state_ff <= rcf_pkg::SW_BUSY;
        sw_cnt_ff <= rcf_pkg::SWITCH_CYC - 4'h1;
        target_ff <= apb_req.pwdata[rcf_pkg::OSC_NXT_LSB +: 3];
      end else if (sw_state_ff == rcf_pkg::SW_BUSY) begin
        if (sw_cnt_ff != 4'h0) sw_cnt_ff <= sw_cnt_ff - 4'h1;
        else sw_state_ff <= rcf_pkg::SW_IDLE;
      end
      if (sw_done && sw_ok) cur_src_ff <= target_ff;
      if (sw_done && !sw_ok) begin
        cur_src_ff <= rcf_pkg::SRC_FAST_RC;
        if (failsafe_clock_monitor_seen_ff) stuck_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      nxt_sel_ff <= rcf_pkg::SRC_RST;
      failsafe_clock_monitor_en_ff <= 1'b0;
      div_ff <= rcf_pkg::DIV_ONE_TO_ONE;
      wdt_en_ff <= 1'b0;
      irq_en_ff <= '0;
    end else begin
      if (wr_osc) begin
        nxt_sel_ff <= apb_req.pwdata[rcf_pkg::OSC_NXT_LSB +: 3];
        failsafe_clock_monitor_en_ff <= apb_req.pwdata[rcf_pkg::OSC_FAILSAFE_CLOCK_MONITOR_EN_BIT];
      end
      if (wr_ctrl) begin
        div_ff <= apb_req.pwdata[rcf_pkg::CTRL_DIV_LSB +: 2];
        wdt_en_ff <= apb_req.pwdata[rcf_pkg::CTRL_WDT_EN_BIT];
      end
      if (wr_ien) irq_en_ff <= apb_req.pwdata[IRQ_W_L-1:0];
    end
  end

  // Cause flags: write one to clear, a new cause in the same cycle wins
  assign cause_keep = cause_ff & ~(wr_cause ? apb_req.pwdata[2:0] : 3'h0);
  always_ff @(posedge mclk) begin
    if (sys_rst) cause_ff <= 3'h0;
    else begin
      cause_ff <= cause_keep;
      if (ev_wdt) cause_ff[rcf_pkg::CAUSE_WDT_BIT] <= 1'b1;
      if (ev_ext) cause_ff[rcf_pkg::CAUSE_EXT_BIT] <= 1'b1;
      if (ev_soft) cause_ff[rcf_pkg::CAUSE_SOFT_BIT] <= 1'b1;
    end
  end

  always_comb begin
    irq_ev = '0;
    irq_ev[rcf_pkg::IRQ_EXT_BIT] = ev_ext;
    irq_ev[rcf_pkg::IRQ_SOFT_BIT] = ev_soft;
    irq_ev[rcf_pkg::IRQ_WDT_BIT] = ev_wdt;
    irq_ev[rcf_pkg::IRQ_FAILSAFE_CLOCK_MONITOR_BIT] = ev_failsafe_clock_monitor;
    irq_ev[rcf_pkg::IRQ_SWFAIL_BIT] = ev_swfail;
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_stat_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~(wr_iclr ? apb_req.pwdata[IRQ_W_L-1:0] : '0)) | irq_ev;
      irq_ff <= |(irq_stat_ff & irq_en_ff);
    end
  end

  // Read data is captured in the setup cycle so the access phase needs no wait
  always_ff @(posedge mclk) begin
    if (sys_rst) rsp_ff <= '0;
    else if (setup) begin
      rsp_ff.prdata <= 32'h0;
      rsp_ff.pslverr <= 1'b0;
      unique case (apb_req.paddr)
        rcf_pkg::OFF_OSC: begin
          rsp_ff.prdata[rcf_pkg::OSC_NXT_LSB +: 3] <= nxt_sel_ff;
          rsp_ff.prdata[rcf_pkg::OSC_CUR_LSB +: 3] <= cur_src_ff;
          rsp_ff.prdata[rcf_pkg::OSC_FAIL_BIT] <= failsafe_ff;
          rsp_ff.prdata[rcf_pkg::OSC_STUCK_BIT] <= stuck_ff;
          rsp_ff.prdata[rcf_pkg::OSC_FAILSAFE_CLOCK_MONITOR_EN_BIT] <= failsafe_clock_monitor_en_ff;
        end
        rcf_pkg::OFF_CAUSE: rsp_ff.prdata[2:0] <= cause_ff;
        rcf_pkg::OFF_CTRL: begin
          rsp_ff.prdata[rcf_pkg::CTRL_DIV_LSB +: 2] <= div_ff;
          rsp_ff.prdata[rcf_pkg::CTRL_WDT_EN_BIT] <= wdt_en_ff;
        end
        rcf_pkg::OFF_IRQ_STAT: rsp_ff.prdata[IRQ_W_L-1:0] <= irq_stat_ff;
        rcf_pkg::OFF_IRQ_EN: rsp_ff.prdata[IRQ_W_L-1:0] <= irq_en_ff;
        rcf_pkg::OFF_IRQ_CLR: rsp_ff.prdata <= 32'h0;
        default: rsp_ff.pslverr <= 1'b1;
      endcase
    end
  end

  always_comb begin
    apb_rsp = rsp_ff;
    apb_rsp.pready = apb_req.psel && apb_req.penable;
    apb_rsp.pslverr = rsp_ff.pslverr && apb_req.psel && apb_req.penable;
  end
  assign core_reset_out = core_rst_ff;
  assign clock_source_out = cur_src_ff;
  assign irq = irq_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_short_pulse_drop: assert property ($rose(ext_valid_ff) |->
    !$past(filt_ff[0], 1) && !$past(filt_ff[0], 2) && !$past(filt_ff[0], 3))
    else $error("pin reset taken after fewer than three asserted clocks");
  a_pin_sync_agree: assert property ($fell(filt_ff[0]) |->
    !$past(s2_ff[0]) && !$past(s3_ff[0]))
    else $error("pin level taken before sync stages agreed");
  a_long_reset_failsafe_clock_monitor: assert property (core_rst_ff && ref_edge && ref_edges_ff == 2'h1 && failsafe_clock_monitor_en_ff
    |=> failsafe_ff && cur_src_ff == rcf_pkg::SRC_FAST_RC)
    else $error("long reset did not raise monitor event");
  a_soft_blocked: assert property (soft_req && div_ff == rcf_pkg::DIV_ONE_TO_ONE &&
    core_clk_below_1mhz && !ev_wdt |=> hold_cnt_ff == 4'h0 || $past(hold_cnt_ff) > 4'h1)
    else $error("software reset applied with slow clock and undivided bus");
  a_osc_write_clear: assert property (wr_osc && failsafe_ff && !ev_failsafe_clock_monitor |=>
    !failsafe_ff && sw_state_ff == rcf_pkg::SW_BUSY ##8 sw_state_ff == rcf_pkg::SW_IDLE || ev_failsafe_clock_monitor)
    else $error("oscillator write in failsafe did not clear and switch");
  a_spurious_wdt: assert property ((ev_ext || ev_soft) && wdt_near |=>
    cause_ff[rcf_pkg::CAUSE_WDT_BIT] && core_rst_ff)
    else $error("reset near watchdog expiry missed timeout flag");
  a_cause_separate: assert property (ev_ext && !wdt_near |=>
    cause_ff[rcf_pkg::CAUSE_EXT_BIT] && $stable(cause_ff[rcf_pkg::CAUSE_WDT_BIT]) || ev_wdt)
    else $error("pin reset cause not recorded alone");
  a_switch_stuck: assert property (stuck_ff && sw_done && target_ff != rcf_pkg::SRC_FAST_RC
    && !ev_failsafe_clock_monitor |=> cur_src_ff == rcf_pkg::SRC_FAST_RC [*2])
    else $error("switch away from fast RC succeeded after a failure");
  a_flags_survive: assert property (1'b1 |=> (cause_ff & $past(cause_keep)) == $past(cause_keep))
    else $error("cause flag lost without software clear");
  a_wdt_expiry_flag: assert property (wdt_en_ff && !core_rst_ff && wdt_cnt_ff == WDT_LAST |=>
    cause_ff[rcf_pkg::CAUSE_WDT_BIT] && core_rst_ff)
    else $error("watchdog expiry did not record timeout and reset");
  a_pin_reset_taken: assert property (ev_ext |=> core_rst_ff && cause_ff[rcf_pkg::CAUSE_EXT_BIT])
    else $error("valid pin reset not applied or not recorded");

  c_pin_reset: cover property (ev_ext ##1 core_rst_ff);
  c_failsafe_clock_monitor_then_write: cover property (ev_failsafe_clock_monitor ##[1:20] wr_osc);
  c_spurious_wdt: cover property (ev_wdt && ev_ext);
  c_stuck_retry: cover property (stuck_ff && sw_done);
endmodule : rcf_reset_clock_failsafe

// ==== sim/rcf_board_model.sv ====
/*
  Board-side model: external reset pin driver, free-running fail-safe reference
  clock and clock-failure line. Assumes mclk comes from the testbench.
*/
`timescale 1ns/10ps
module rcf_board_model #(
  parameter int unsigned REF_HALF = 20
) (
  input wire logic mclk,
  output logic external_reset_pin_n,
  output logic ref_clk_31k,
  output logic clk_fail_pin
);
  int unsigned ref_cnt;
  initial begin
    external_reset_pin_n = 1'b1;
    ref_clk_31k = 1'b0;
    clk_fail_pin = 1'b0;
    ref_cnt = 0;
  end
  // Scaled reference: a true 31 kHz period would cost hundreds of cycles per test
  always @(posedge mclk) begin
    ref_cnt <= (ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
    if (ref_cnt == REF_HALF - 1) begin
      ref_clk_31k <= ~ref_clk_31k;
    end
  end
  // Pin held low for cyc clocks; only the short-pulse test uses two or fewer
  task automatic pin_pulse(input int unsigned cyc);
    @(posedge mclk);
    external_reset_pin_n <= 1'b0;
    repeat (cyc) @(posedge mclk);
    external_reset_pin_n <= 1'b1;
  endtask : pin_pulse
  task automatic fail_pulse();
    @(posedge mclk);
    clk_fail_pin <= 1'b1;
    repeat (3) @(posedge mclk);
    clk_fail_pin <= 1'b0;
  endtask : fail_pulse
endmodule : rcf_board_model

// ==== sim/testbench.sv ====
/*
  Self-checking bench: APB master tasks and directed reset, watchdog and
  oscillator tests. Assumes the board model and a short watchdog count.
*/
`timescale 1ns/10ps
module testbench;
  logic mclk;
  logic sys_rst;
  rcf_pkg::rcf_apb_req_s req;
  rcf_pkg::rcf_apb_rsp_s rsp;
  logic ext_n, ref_clk, fail, osc_ready, below_1mhz, core_rst, irq;
  logic [2:0] src;
  logic [31:0] q;
  logic e;
  int err_count, cmp_count, rst_hi, rst_base;

  rcf_reset_clock_failsafe #(.WDT_TIMEOUT_CYC(64)) dut (.mclk(mclk), .sys_rst(sys_rst), .apb_req(req),
    .apb_rsp(rsp), .external_reset_pin_n(ext_n), .ref_clk_31k(ref_clk), .clk_fail_pin(fail),
    .osc_ready(osc_ready), .core_clk_below_1mhz(below_1mhz), .core_reset_out(core_rst),
    .clock_source_out(src), .irq(irq));
  rcf_board_model board (.mclk(mclk), .external_reset_pin_n(ext_n), .ref_clk_31k(ref_clk),
    .clk_fail_pin(fail));

  always @(posedge mclk) begin
    if (core_rst === 1'b1) begin
      rst_hi <= rst_hi + 1;
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // Waits on pready as long as it takes; only the 20000-cycle bench timeout ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge mclk);
    req.penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, q, x);
  endtask : rd
  task automatic summarize();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    summarize();
  end

  initial begin
    sys_rst = 1'b1;
    req = '0;
    osc_ready = 1'b1;
    below_1mhz = 1'b0;
    err_count = 0;
    cmp_count = 0;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i), 32'h0, "rst val");
    end
    xfer(1'b0, 8'h18, 32'h0);
    chk("slverr", {31'h0, e}, 32'h1);
    chk("unmapped", q, 32'h0);
    wr(rcf_pkg::OFF_IRQ_EN, 32'h1f);
    rd(rcf_pkg::OFF_IRQ_EN, 32'h1f, "irq en");
    board.pin_pulse(2);
    repeat (10) @(posedge mclk);
    chk("short rst", rst_hi, 0);
    rd(rcf_pkg::OFF_CAUSE, 32'h0, "cause short");
    board.pin_pulse(6);
    repeat (10) @(posedge mclk);
    chk("long rst", {31'h0, rst_hi != 0}, 32'h1);
    rd(rcf_pkg::OFF_CAUSE, 32'h2, "cause ext");
    rd(rcf_pkg::OFF_IRQ_STAT, 32'h1, "stat ext");
    chk("irq", {31'h0, irq}, 32'h1);
    wr(rcf_pkg::OFF_IRQ_EN, 32'h0);
    repeat (2) @(posedge mclk);
    chk("irq mask", {31'h0, irq}, 32'h0);
    wr(rcf_pkg::OFF_IRQ_CLR, 32'h1f);
    rd(rcf_pkg::OFF_IRQ_STAT, 32'h0, "stat clr");
    wr(rcf_pkg::OFF_IRQ_EN, 32'h1f);
    wr(rcf_pkg::OFF_CAUSE, 32'h7);
    rd(rcf_pkg::OFF_CAUSE, 32'h0, "cause clr");
    below_1mhz <= 1'b1;
    rst_base = rst_hi;
    wr(rcf_pkg::OFF_CTRL, 32'h1);
    repeat (8) @(posedge mclk);
    chk("sw refused", rst_hi - rst_base, 0);
    rd(rcf_pkg::OFF_CAUSE, 32'h0, "cause refused");
    // The divider must already stand at the write that asks for the reset
    wr(rcf_pkg::OFF_CTRL, 32'h2);
    wr(rcf_pkg::OFF_CTRL, 32'h3);
    repeat (8) @(posedge mclk);
    chk("sw rst len", rst_hi - rst_base, 4);
    rd(rcf_pkg::OFF_CAUSE, 32'h4, "cause sw");
    rd(rcf_pkg::OFF_IRQ_STAT, 32'h2, "stat sw");
    below_1mhz <= 1'b0;
    wr(rcf_pkg::OFF_CAUSE, 32'h7);
    wr(rcf_pkg::OFF_CTRL, 32'h18);
    board.pin_pulse(5);
    repeat (8) @(posedge mclk);
    rd(rcf_pkg::OFF_CAUSE, 32'h2, "early pin");
    wr(rcf_pkg::OFF_CAUSE, 32'h7);
    repeat (70) @(posedge mclk);
    rd(rcf_pkg::OFF_CAUSE, 32'h1, "wdt only");
    wr(rcf_pkg::OFF_CAUSE, 32'h7);
    wr(rcf_pkg::OFF_CTRL, 32'h18);
    repeat (42) @(posedge mclk);
    board.pin_pulse(8);
    wr(rcf_pkg::OFF_CTRL, 32'h0);
    repeat (6) @(posedge mclk);
    rd(rcf_pkg::OFF_CAUSE, 32'h3, "late pin");
    wr(rcf_pkg::OFF_IRQ_CLR, 32'h1f);
    wr(rcf_pkg::OFF_OSC, 32'h1000);
    board.pin_pulse(100);
    repeat (8) @(posedge mclk);
    rd(rcf_pkg::OFF_OSC, 32'h1100, "long rst mon");
    rd(rcf_pkg::OFF_IRQ_STAT, 32'h9, "stat mon");
    wr(rcf_pkg::OFF_OSC, 32'h0);
    rd(rcf_pkg::OFF_OSC, 32'h0, "fail clr");
    wr(rcf_pkg::OFF_IRQ_CLR, 32'h1f);
    board.pin_pulse(100);
    repeat (8) @(posedge mclk);
    rd(rcf_pkg::OFF_OSC, 32'h0, "mon off");
    rd(rcf_pkg::OFF_IRQ_STAT, 32'h1, "stat no mon");
    wr(rcf_pkg::OFF_IRQ_CLR, 32'h1f);
    wr(rcf_pkg::OFF_OSC, 32'h1002);
    board.fail_pulse();
    repeat (6) @(posedge mclk);
    rd(rcf_pkg::OFF_OSC, 32'h1102, "fail set");
    wr(rcf_pkg::OFF_OSC, 32'h1002);
    repeat (10) @(posedge mclk);
    rd(rcf_pkg::OFF_OSC, 32'h1022, "switch new");
    chk("src new", {29'h0, src}, 32'h2);
    board.fail_pulse();
    repeat (6) @(posedge mclk);
    wr(rcf_pkg::OFF_OSC, 32'h1000);
    repeat (10) @(posedge mclk);
    rd(rcf_pkg::OFF_OSC, 32'h1000, "back frc");
    osc_ready <= 1'b0;
    wr(rcf_pkg::OFF_OSC, 32'h11002);
    repeat (10) @(posedge mclk);
    rd(rcf_pkg::OFF_OSC, 32'h1202, "stuck");
    rd(rcf_pkg::OFF_IRQ_STAT, 32'h18, "stat swfail");
    osc_ready <= 1'b1;
    wr(rcf_pkg::OFF_OSC, 32'h11002);
    repeat (10) @(posedge mclk);
    rd(rcf_pkg::OFF_OSC, 32'h1202, "retry");
    chk("src retry", {29'h0, src}, 32'h0);
    summarize();
  end
endmodule : testbench
